// *** rtl/cmp_page_drive.sv ***
// drive end: checks a received compression page, returns the sensed page
// assumes the initiator streams 16 bytes one per out_valid after select_start
// Function
// - page accepted only with page format set
// - page code bits 5..0 must be 0fh
// - page length must be 0eh, echoed 0eh
// - compress enable bit must be zero
// - sensed compress capable bit is zero
// - decompress enable bit must be zero
// - exception report field must be 00
// - compression algorithm bytes 4..7 zero
// - decompression algorithm bytes 8..11 zero
// - bytes 12..15 reserved, returned as zero
`timescale 1ns/10ps
module cmp_page_drive (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link
    cmp_page_if.drive link,
    // drive side
    output logic accepted_q,
    output logic rejected_q
);
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        RECV = 2'b01,
        SEND = 2'b10,
        DONE = 2'b11
    } state_t;

    // kind of command in flight
    typedef enum logic {
        CMD_SELECT = 1'b0,
        CMD_SENSE = 1'b1
    } cmd_t;

    state_t state_q;
    cmd_t cmd_q;
    logic [3:0] idx_q;
    logic last_idx;
    logic bad_q;
    logic pf_q;
    logic reject;
    logic [cmp_page_pkg::PAGE_BYTES-1:0] pos_bad;
    logic [7:0] sense_table [cmp_page_pkg::PAGE_BYTES];
    logic byte_bad;
    logic [7:0] sense_byte;
    logic [1:0] status_q;
    logic [3:0] key_q;
    logic done_q;
    logic in_valid_q;
    logic [7:0] in_byte_q;

    // per position: field check on receive, byte value on return
    for (genvar i = 0; i < cmp_page_pkg::PAGE_BYTES; i++) begin : g_pos
        localparam logic [3:0] POS = 4'(i);
        if (POS == cmp_page_pkg::BYTE_CODE) begin : g_code
            assign pos_bad[i] = link.out_byte[5:0] != cmp_page_pkg::PAGE_CODE;
            assign sense_table[i] = {2'h0, cmp_page_pkg::PAGE_CODE};
        end else if (POS == cmp_page_pkg::BYTE_LEN) begin : g_len
            assign pos_bad[i] = link.out_byte != cmp_page_pkg::PAGE_LEN;
            assign sense_table[i] = cmp_page_pkg::PAGE_LEN;
        end else if (POS == cmp_page_pkg::BYTE_CTL) begin : g_ctl
            assign pos_bad[i] = link.out_byte[cmp_page_pkg::COMPRESS_ENABLE_POS];
            assign sense_table[i] = 8'h00;
        end else if (POS == cmp_page_pkg::BYTE_DCTL) begin : g_dctl
            assign pos_bad[i] = link.out_byte[cmp_page_pkg::DECOMPRESS_ENABLE_POS]
                | (|link.out_byte[cmp_page_pkg::EXC_REPORT_HI:cmp_page_pkg::EXC_REPORT_LO]);
            assign sense_table[i] = 8'h00;
        end else if (POS >= cmp_page_pkg::BYTE_CALG_FIRST
                && POS <= cmp_page_pkg::BYTE_DALG_LAST) begin : g_alg
            assign pos_bad[i] = |link.out_byte;
            assign sense_table[i] = 8'h00;
        end else begin : g_rsvd
            assign pos_bad[i] = 1'b0;
            assign sense_table[i] = 8'h00;
        end
    end

    // the position now on the link
    assign byte_bad = pos_bad[idx_q];
    assign sense_byte = sense_table[idx_q];
    assign last_idx = idx_q == 4'(cmp_page_pkg::PAGE_BYTES - 1);

    // command sequencing
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= IDLE;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (link.select_start) begin
                        state_q <= RECV;
                    end else if (link.sense_start) begin
                        state_q <= SEND;
                    end
                end
                RECV: begin
                    if (link.out_valid && last_idx) begin
                        state_q <= DONE;
                    end
                end
                SEND: begin
                    if (last_idx) begin
                        state_q <= DONE;
                    end
                end
                DONE: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    // byte position within the page
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idx_q <= 4'h0;
        end else if (state_q == IDLE) begin
            idx_q <= 4'h0;
        end else if (state_q == SEND || (state_q == RECV && link.out_valid)) begin
            idx_q <= idx_q + 4'h1;
        end
    end

    // command kind and page format flag, caught at the start
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q <= CMD_SELECT;
            pf_q <= 1'b0;
        end else if (state_q == IDLE) begin
            if (link.select_start) begin
                cmd_q <= CMD_SELECT;
                pf_q <= link.page_format;
            end else if (link.sense_start) begin
                cmd_q <= CMD_SENSE;
            end
        end
    end

    // any unsupported field seen in the received page
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bad_q <= 1'b0;
        end else if (state_q == IDLE) begin
            bad_q <= 1'b0;
        end else if (state_q == RECV && link.out_valid) begin
            bad_q <= bad_q | byte_bad;
        end
    end

    // a received page without page format or with a bad field
    assign reject = cmd_q == CMD_SELECT && (bad_q || !pf_q);

    // returned page bytes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            in_valid_q <= 1'b0;
            in_byte_q <= 8'h00;
        end else begin
            in_valid_q <= state_q == SEND;
            in_byte_q <= (state_q == SEND) ? sense_byte : 8'h00;
        end
    end

    // end of command pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= state_q == DONE;
        end
    end

    // completion status, held until the next command ends
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= cmp_page_pkg::STATUS_GOOD;
            key_q <= cmp_page_pkg::SENSE_NONE;
        end else if (state_q == DONE) begin
            if (reject) begin
                status_q <= cmp_page_pkg::STATUS_CHECK;
                key_q <= cmp_page_pkg::SENSE_ILLEGAL_REQUEST;
            end else begin
                status_q <= cmp_page_pkg::STATUS_GOOD;
                key_q <= cmp_page_pkg::SENSE_NONE;
            end
        end
    end

    // one-cycle verdict pulses for a received page
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            accepted_q <= 1'b0;
            rejected_q <= 1'b0;
        end else begin
            accepted_q <= state_q == DONE && cmd_q == CMD_SELECT && !reject;
            rejected_q <= state_q == DONE && reject;
        end
    end

    assign link.in_valid = in_valid_q;
    assign link.in_byte = in_byte_q;
    assign link.done = done_q;
    assign link.status = status_q;
    assign link.sense_key = key_q;
endmodule

// *** rtl/cmp_page_pkg.sv ***
// constants for the compression parameter page checker
// assumes one system clock and active-low asynchronous reset
package cmp_page_pkg;
    localparam logic [5:0] PAGE_CODE = 6'h0f;
    localparam logic [7:0] PAGE_LEN = 8'h0e;
    localparam int PAGE_BYTES = 16;
    localparam logic [3:0] BYTE_CODE = 4'h0;
    localparam logic [3:0] BYTE_LEN = 4'h1;
    localparam logic [3:0] BYTE_CTL = 4'h2;
    localparam logic [3:0] BYTE_DCTL = 4'h3;
    localparam logic [3:0] BYTE_CALG_FIRST = 4'h4;
    localparam logic [3:0] BYTE_DALG_LAST = 4'hb;
    localparam int COMPRESS_ENABLE_POS = 7;
    localparam int COMPRESS_CAPABLE_POS = 6;
    localparam int DECOMPRESS_ENABLE_POS = 7;
    localparam int EXC_REPORT_HI = 6;
    localparam int EXC_REPORT_LO = 5;
    localparam logic [1:0] STATUS_GOOD = 2'h0;
    localparam logic [1:0] STATUS_CHECK = 2'h1;
    localparam logic [3:0] SENSE_NONE = 4'h0;
    localparam logic [3:0] SENSE_ILLEGAL_REQUEST = 4'h5;
endpackage

// *** rtl/cmp_page_if.sv ***
// byte link between initiator end and drive end for the page
// assumes both ends share clk_sys
`timescale 1ns/10ps
interface cmp_page_if;
    logic select_start;
    logic sense_start;
    logic page_format;
    logic out_valid;
    logic [7:0] out_byte;
    logic in_valid;
    logic [7:0] in_byte;
    logic done;
    logic [1:0] status;
    logic [3:0] sense_key;
    modport drive (
        input select_start, sense_start, page_format, out_valid, out_byte,
        output in_valid, in_byte, done, status, sense_key
    );
    modport initiator (
        output select_start, sense_start, page_format, out_valid, out_byte,
        input in_valid, in_byte, done, status, sense_key
    );
endinterface

// *** rtl/cmp_page_initiator.sv ***
// initiator end: sends a compression page or asks for the sensed page
// assumes the drive end answers on the shared link
`timescale 1ns/10ps
module cmp_page_initiator (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link
    cmp_page_if.initiator link,
    // user side
    input wire logic send_req,
    input wire logic sense_req,
    input wire logic [7:0] user_byte_ctl,
    output logic busy_q,
    output logic check_q,
    output logic [7:0] last_sensed_q
);
    logic [4:0] cnt_q;
    logic sending_q;
    logic sel_q;
    logic sns_q;
    logic ov_q;
    logic [7:0] ob_q;
    logic [7:0] page_byte;

    always_comb begin
        page_byte = 8'h00;
        if (cnt_q == 5'h0) begin
            page_byte = {2'h0, cmp_page_pkg::PAGE_CODE};
        end else if (cnt_q == 5'h1) begin
            page_byte = cmp_page_pkg::PAGE_LEN;
        end else if (cnt_q == 5'h2) begin
            page_byte = user_byte_ctl & 8'h3f;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 5'h0;
            sending_q <= 1'b0;
            sel_q <= 1'b0;
            sns_q <= 1'b0;
            ov_q <= 1'b0;
            ob_q <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            sel_q <= 1'b0;
            sns_q <= 1'b0;
            ov_q <= 1'b0;
            if (!busy_q && send_req) begin
                sel_q <= 1'b1;
                busy_q <= 1'b1;
                sending_q <= 1'b1;
                cnt_q <= 5'h0;
            end else if (!busy_q && sense_req) begin
                sns_q <= 1'b1;
                busy_q <= 1'b1;
            end else if (sending_q) begin
                ov_q <= 1'b1;
                ob_q <= page_byte;
                cnt_q <= cnt_q + 5'h1;
                if (cnt_q == 5'(cmp_page_pkg::PAGE_BYTES - 1)) begin
                    sending_q <= 1'b0;
                end
            end else if (link.done) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            check_q <= 1'b0;
            last_sensed_q <= 8'h00;
        end else begin
            if (link.done) begin
                check_q <= link.status == cmp_page_pkg::STATUS_CHECK;
            end
            if (link.in_valid) begin
                last_sensed_q <= link.in_byte;
            end
        end
    end

    assign link.select_start = sel_q;
    assign link.sense_start = sns_q;
    assign link.page_format = 1'b1;
    assign link.out_valid = ov_q;
    assign link.out_byte = ob_q;
endmodule

// *** verification/cmp_page_chk.sv ***
// link checker between initiator end and drive end
// assumes it sits beside the interface joining the two ends
`timescale 1ns/10ps
module cmp_page_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // link
    input wire logic select_start,
    input wire logic sense_start,
    input wire logic page_format,
    input wire logic out_valid,
    input wire logic [7:0] out_byte,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic done,
    input wire logic [1:0] status,
    input wire logic [3:0] sense_key
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_sent_head;
        out_valid && out_byte[5:0] == cmp_page_pkg::PAGE_CODE
        ##1 out_valid && out_byte == cmp_page_pkg::PAGE_LEN;
    endsequence
    sequence s_sensed_head;
        in_valid && in_byte[5:0] == cmp_page_pkg::PAGE_CODE
        ##1 in_valid && in_byte == cmp_page_pkg::PAGE_LEN
        ##1 in_valid && in_byte[7:6] == 2'h0;
    endsequence
    sequence s_good_end;
        done && status == cmp_page_pkg::STATUS_GOOD && sense_key == cmp_page_pkg::SENSE_NONE;
    endsequence
    a_format_set: assert property (select_start |-> page_format)
        else $error("page format low at select");
    a_sent_head: assert property (select_start |=> s_sent_head)
        else $error("bad sent code or length");
    a_enable_clear: assert property (select_start |-> ##3 out_valid && !out_byte[7])
        else $error("compress enable sent set");
    a_dctl_clear: assert property (select_start |-> ##4 out_valid && out_byte[7:5] == 3'h0)
        else $error("decompress control sent set");
    a_alg_zero: assert property (select_start |-> ##5 (out_valid && out_byte == 8'h00) [*8])
        else $error("algorithm bytes not zero");
    a_sense_head: assert property (sense_start |-> ##2 s_sensed_head)
        else $error("bad sensed head");
    a_reserved_zero: assert property (sense_start |-> ##14 (in_valid && in_byte == 8'h00) [*4])
        else $error("sensed reserved not zero");
    a_select_good: assert property (select_start |-> ##18 s_good_end)
        else $error("good page not accepted");
endmodule

// *** verification/tb_compression_mode_page_checker.sv ***
// bench: initiator and drive end joined, plus a drive end fed bad pages
// assumes a 250 MHz clk_sys and active-low reset_n
`timescale 1ns/10ps
module tb_compression_mode_page_checker;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic send_req = 1'b0;
    logic sense_req = 1'b0;
    logic [7:0] user_byte_ctl = 8'h00;
    logic busy_q, check_q, acc_q, rej_q, acc2_q, rej2_q;
    logic [7:0] last_sensed_q;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int acc_n = 0;
    int rej_n = 0;
    int n_sensed = 0;
    logic [7:0] sensed [16];
    cmp_page_if l1();
    cmp_page_if l2();
    cmp_page_initiator u_cmp_page_initiator (.clk_sys(clk_sys), .reset_n(reset_n), .link(l1),
        .send_req(send_req), .sense_req(sense_req), .user_byte_ctl(user_byte_ctl),
        .busy_q(busy_q), .check_q(check_q), .last_sensed_q(last_sensed_q));
    cmp_page_drive u_cmp_page_drive (.clk_sys(clk_sys), .reset_n(reset_n), .link(l1),
        .accepted_q(acc_q), .rejected_q(rej_q));
    cmp_page_drive u_cmp_page_drive_2 (.clk_sys(clk_sys), .reset_n(reset_n), .link(l2),
        .accepted_q(acc2_q), .rejected_q(rej2_q));
    cmp_page_chk u_cmp_page_chk (.clk_sys(clk_sys), .reset_n(reset_n),
        .select_start(l1.select_start), .sense_start(l1.sense_start),
        .page_format(l1.page_format), .out_valid(l1.out_valid), .out_byte(l1.out_byte),
        .in_valid(l1.in_valid), .in_byte(l1.in_byte), .done(l1.done), .status(l1.status),
        .sense_key(l1.sense_key));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        l2.select_start = 1'b0;
        l2.sense_start = 1'b0;
        l2.page_format = 1'b0;
        l2.out_valid = 1'b0;
        l2.out_byte = 8'h00;
    end
    always @(negedge clk_sys) begin
        cyc++;
        acc_n += (acc_q === 1'b1) + (acc2_q === 1'b1);
        rej_n += (rej_q === 1'b1) + (rej2_q === 1'b1);
        if (l1.in_valid === 1'b1 && n_sensed < 16) begin
            sensed[n_sensed] = l1.in_byte;
            n_sensed++;
        end
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic user_cmd(input logic sel);
        int k;
        k = 0;
        @(negedge clk_sys);
        send_req = sel;
        sense_req = !sel;
        @(negedge clk_sys);
        send_req = 1'b0;
        sense_req = 1'b0;
        while (busy_q !== 1'b0 && k < 40) begin
            @(negedge clk_sys);
            k++;
        end
    endtask
    task automatic send_page(input logic pf, input int idx, input logic [7:0] val,
        input logic bad);
        logic [7:0] pg [16];
        logic [1:0] exp_status;
        logic [3:0] exp_key;
        int k;
        int r0;
        int a0;
        r0 = rej_n;
        a0 = acc_n;
        exp_status = bad ? cmp_page_pkg::STATUS_CHECK : cmp_page_pkg::STATUS_GOOD;
        exp_key = bad ? cmp_page_pkg::SENSE_ILLEGAL_REQUEST : cmp_page_pkg::SENSE_NONE;
        for (k = 0; k < 16; k++) begin
            pg[k] = 8'h00;
        end
        pg[0] = {2'h0, cmp_page_pkg::PAGE_CODE};
        pg[1] = cmp_page_pkg::PAGE_LEN;
        pg[idx] = val;
        @(negedge clk_sys);
        l2.page_format = pf;
        l2.select_start = 1'b1;
        for (k = 0; k < 16; k++) begin
            @(negedge clk_sys);
            l2.select_start = 1'b0;
            l2.out_valid = 1'b1;
            l2.out_byte = pg[k];
        end
        @(negedge clk_sys);
        l2.out_valid = 1'b0;
        k = 0;
        while (l2.done !== 1'b1 && k < 8) begin
            @(negedge clk_sys);
            k++;
        end
        check(l2.status === exp_status, "status");
        check(l2.sense_key === exp_key, "sense key");
        @(negedge clk_sys);
        check((rej_n - r0) == (bad ? 1 : 0), "reject pulse");
        check((acc_n - a0) == (bad ? 0 : 1), "accept pulse");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        user_byte_ctl = 8'hff;
        user_cmd(1'b1);
        check(check_q === 1'b0 && acc_n == 1, "send refused");
        $display("test select done");
        user_cmd(1'b0);
        check(check_q === 1'b0 && last_sensed_q === 8'h00, "sensed tail");
        check(n_sensed == 16 && acc_n == 1 && rej_n == 0, "sensed count");
        check(sensed[0] === {2'h0, cmp_page_pkg::PAGE_CODE}, "sensed code");
        check(sensed[1] === cmp_page_pkg::PAGE_LEN, "sensed length");
        check(sensed[2][cmp_page_pkg::COMPRESS_CAPABLE_POS] === 1'b0, "sensed capable");
        check(sensed[12] === 8'h00 && sensed[15] === 8'h00, "sensed reserved");
        $display("test sense done");
        send_page(1'b0, 12, 8'h00, 1'b1);
        send_page(1'b1, 0, 8'h0e, 1'b1);
        send_page(1'b1, 1, 8'h0d, 1'b1);
        send_page(1'b1, 2, 8'h80, 1'b1);
        send_page(1'b1, 3, 8'h80, 1'b1);
        send_page(1'b1, 3, 8'h40, 1'b1);
        send_page(1'b1, 3, 8'h20, 1'b1);
        send_page(1'b1, 4, 8'h01, 1'b1);
        send_page(1'b1, 11, 8'h01, 1'b1);
        send_page(1'b1, 12, 8'h5a, 1'b0);
        $display("test bad pages done");
        conclude();
    end
endmodule
